/* core/kich_handler.sv */
// key install command handler: packet parser, checks, key relay, reply sender
`include "kich_params.svh"
module kich_handler #(
  parameter int unsigned ERR_DELAY_CYCLES = `KICH_ERR_DELAY_S * `KICH_CLK_HZ
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic rxValid, // received byte strobe
  input wire logic [7:0] rxByte, // received byte
  output logic txValid, // reply byte valid
  output logic [7:0] txByte, // reply byte
  input wire logic txReady, // link takes reply byte
  output logic keyValid, // key data byte strobe
  output logic [7:0] keyByte, // key data byte to trusted system
  output logic genReq, // start key index generation
  output logic [7:0] genType, // key type for generation
  input wire logic genDone, // generation finished
  input wire logic genFail, // generation failed
  input wire logic genAbnormal, // trusted system abnormal
  output logic flashReq, // start key index write
  output logic [31:0] flashAddr, // key store location
  output logic [11:0] flashLen, // key index size in bytes
  input wire logic flashDone, // write finished
  input wire logic flashFail, // write failed
  input wire logic [31:0] flashStatus, // sequencer status details
  input wire logic [31:0] flashFailAddr, // failing location
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr // apb error
);
  ////////////////////////////////////////////////////////////////////////////
  kich_pkg::kich_regs_t q, d; // state and next state
  logic [24:0] kt; // table result: valid, install size, index size
  logic [32:0] rangeEnd; // end of target range
  logic apbAcc; // apb access completes this edge
  // install size / index size per key type, valid flag on top
  function automatic logic [24:0] keyTable(input logic [7:0] t);
    case (t)
      8'h05: keyTable = {1'b1, 12'h020, 12'h024};
      8'h06, 8'h07, 8'h08, 8'h13, 8'h15, 8'h17, 8'h1a, 8'h1b, 8'h1d, 8'h23, 8'hff:
        keyTable = {1'b1, 12'h030, 12'h034};
      8'h09, 8'h12, 8'h14, 8'h16, 8'h1c, 8'h21, 8'h22:
        keyTable = {1'b1, 12'h050, 12'h054};
      8'h0a: keyTable = {1'b1, 12'h0a0, 12'h124};
      8'h0b: keyTable = {1'b1, 12'h110, 12'h194};
      8'h0c: keyTable = {1'b1, 12'h120, 12'h224};
      8'h0d: keyTable = {1'b1, 12'h210, 12'h314};
      8'h0e: keyTable = {1'b1, 12'h1a0, 12'h1a4};
      8'h0f: keyTable = {1'b1, 12'h310, 12'h314};
      8'h10: keyTable = {1'b1, 12'h220, 12'h224};
      8'h11: keyTable = {1'b1, 12'h410, 12'h414};
      8'h18, 8'h1e: keyTable = {1'b1, 12'h070, 12'h074};
      8'h19, 8'h1f: keyTable = {1'b1, 12'h040, 12'h044};
      8'h20: keyTable = {1'b1, 12'h090, 12'h094};
      default: keyTable = 25'h0000000;
    endcase
  endfunction : keyTable
  // reply code from status
  function automatic logic [7:0] replyCode(input logic [7:0] s);
    replyCode = (s == `KICH_STS_OK) ? `KICH_CMD_CODE : `KICH_ERR_REPLY;
  endfunction : replyCode
  // check byte making the byte sum zero
  function automatic logic [7:0] replySum(input logic [7:0] s, input logic [31:0] a,
                                          input logic [31:0] b);
    logic [7:0] acc;
    acc = `KICH_REPLY_LEN_HI + `KICH_REPLY_LEN_LO + replyCode(s) + s;
    for (int i = 0; i < 4; i++) begin
      acc = acc + a[8*i +: 8] + b[8*i +: 8];
    end
    replySum = 8'h00 - acc;
  endfunction : replySum
  // byte of the reply at a given position
  function automatic logic [7:0] replyByte(input kich_pkg::kich_regs_t r, input logic [3:0] i);
    case (i)
      4'h0: replyByte = `KICH_DATA_START;
      4'h1: replyByte = `KICH_REPLY_LEN_HI;
      4'h2: replyByte = `KICH_REPLY_LEN_LO;
      4'h3: replyByte = replyCode(r.sts);
      4'h4: replyByte = r.sts;
      4'h5, 4'h6, 4'h7, 4'h8: replyByte = r.detail[8*(4'h8 - i) +: 8];
      4'h9, 4'ha, 4'hb, 4'hc: replyByte = r.failAddr[8*(4'hc - i) +: 8];
      4'hd: replyByte = replySum(r.sts, r.detail, r.failAddr);
      default: replyByte = `KICH_END_MARK;
    endcase
  endfunction : replyByte
  // load a reply and enter the send state
  function automatic kich_pkg::kich_regs_t reply(input kich_pkg::kich_regs_t r,
      input logic [7:0] s, input logic [31:0] det, input logic [31:0] adr, input logic more);
    reply = r;
    reply.st = kich_pkg::ST_SEND;
    reply.sts = s;
    reply.detail = det;
    reply.failAddr = adr;
    reply.afterOk = more;
    reply.txIdx = 4'h0;
    reply.txValid = 1'b1;
    reply.txByte = `KICH_DATA_START;
  endfunction : reply
  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb begin
    d = q;
    d.keyValid = 1'b0; // pulses
    d.genReq = 1'b0;
    d.flashReq = 1'b0;
    kt = keyTable(q.ktype);
    rangeEnd = {1'b0, q.addr} + {21'h0, q.idxSize};
    apbAcc = psel & penable & q.pready;
    unique case (q.st)
      kich_pkg::ST_HUNT: begin
        // wait for the expected start byte, others are dropped
        if (rxValid && rxByte == (q.isData ? `KICH_DATA_START : `KICH_CMD_START)) begin
          d.st = kich_pkg::ST_LENH;
          d.sum = 8'h00;
        end
      end
      kich_pkg::ST_LENH: begin
        if (rxValid) begin
          d.len[15:8] = rxByte;
          d.sum = q.sum + rxByte;
          d.st = kich_pkg::ST_LENL;
        end
      end
      kich_pkg::ST_LENL: begin
        if (rxValid) begin
          d.len[7:0] = rxByte;
          d.sum = q.sum + rxByte;
          d.idx = 16'h0000;
          d.resOk = 1'b1;
          d.overflow = 1'b0;
          d.st = ({q.len[15:8], rxByte} == 16'h0000) ? kich_pkg::ST_SUMB : kich_pkg::ST_BODY;
        end
      end
      kich_pkg::ST_BODY: begin
        if (rxValid) begin
          d.sum = q.sum + rxByte;
          d.idx = q.idx + 16'h0001;
          if (!q.isData) begin
            // code, location high byte first, key type
            if (q.idx == 16'h0000) d.code = rxByte;
            else if (q.idx < 16'h0005) d.addr = {q.addr[23:0], rxByte};
            else if (q.idx == 16'h0005) d.ktype = rxByte;
          end else if (q.idx == 16'h0000) begin
            d.resOk = (rxByte == `KICH_CMD_CODE);
          end else begin
            // relay session key, vector and install data
            d.keyValid = 1'b1;
            d.keyByte = rxByte;
            if (!q.firstPkt || q.idx >= `KICH_FIRST_HDR) begin
              // running count of install bytes
              if (q.keyCnt >= q.instSize) d.overflow = 1'b1;
              else d.keyCnt = q.keyCnt + 12'h001;
            end
          end
          if (d.idx == q.len) d.st = kich_pkg::ST_SUMB;
        end
      end
      kich_pkg::ST_SUMB: begin
        if (rxValid) begin
          d.sum = q.sum + rxByte;
          d.st = kich_pkg::ST_ENDB;
        end
      end
      kich_pkg::ST_ENDB: begin
        if (rxValid) begin
          d.delayCnt = 32'(ERR_DELAY_CYCLES - 1);
          if (!q.isData) begin
            // framing checks in priority order
            if (rxByte != `KICH_END_MARK)
              d = reply(q, `KICH_STS_PKT, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
            else if (q.sum != 8'h00)
              d = reply(q, `KICH_STS_SUM, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
            else if (q.len != `KICH_CMD_LEN || q.code != `KICH_CMD_CODE)
              d = reply(q, `KICH_STS_PKT, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
            else
              d.st = kich_pkg::ST_CHECK;
          end else begin
            // data framing errors answer only after the delay
            d.st = kich_pkg::ST_HOLD;
            if (rxByte != `KICH_END_MARK) d.pendSts = `KICH_STS_PKT;
            else if (q.sum != 8'h00) d.pendSts = `KICH_STS_SUM;
            else if (q.len > `KICH_DATA_MAX ||
                     q.len < (q.firstPkt ? `KICH_FIRST_MIN : `KICH_LATER_MIN))
              d.pendSts = `KICH_STS_PKT;
            else if (!q.resOk) d.pendSts = `KICH_STS_PKT;
            else if (q.overflow)
              d = reply(q, `KICH_STS_PARAM, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
            else if (q.keyCnt == q.instSize) begin
              d.st = kich_pkg::ST_GEN; // all key data
              d.genReq = 1'b1;
            end else begin
              d.st = kich_pkg::ST_HUNT; // more data packets follow
              d.firstPkt = 1'b0;
            end
          end
        end
      end
      kich_pkg::ST_CHECK: begin
        // acceptance, then parameters, secure, protection
        d.instSize = kt[23:12];
        d.idxSize = kt[11:0];
        d.keyCnt = 12'h000;
        d.firstPkt = 1'b1;
        if (!q.ctrl[0])
          d = reply(d, `KICH_STS_ACC, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
        else if (!kt[24])
          d = reply(d, `KICH_STS_PARAM, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
        else if (q.addr < q.areaStart || rangeEnd > {1'b0, q.areaEnd})
          d = reply(d, `KICH_STS_PARAM, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
        else if (q.addr < q.split && rangeEnd > {1'b0, q.split})
          d = reply(d, `KICH_STS_PARAM, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
        else if (q.write_access_unit == 32'h0 || (q.addr & (q.write_access_unit - 32'h1)) != 32'h0)
          d = reply(d, `KICH_STS_PARAM, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
        else if (q.ctrl[1] && q.addr < q.secEnd)
          d = reply(d, `KICH_STS_SEC, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
        else if (q.addr < q.protEnd && rangeEnd > {1'b0, q.protStart})
          d = reply(d, `KICH_STS_PROT, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
        else
          d = reply(d, `KICH_STS_OK, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b1);
      end
      kich_pkg::ST_HOLD: begin
        // five second silence before a data framing error reply
        d.delayCnt = q.delayCnt - 32'h1;
        if (q.delayCnt == 32'h0)
          d = reply(q, q.pendSts, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
      end
      kich_pkg::ST_GEN: begin
        if (genAbnormal) begin
          d.st = kich_pkg::ST_HUNT; // no reply at all
          d.isData = 1'b0;
        end else if (genFail) // flash left alone
          d = reply(q, `KICH_STS_TRUST, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
        else if (genDone) begin
          d.st = kich_pkg::ST_FLASH; // write the index
          d.flashReq = 1'b1;
        end
      end
      kich_pkg::ST_FLASH: begin
        if (flashFail)
          d = reply(q, `KICH_STS_FLASH, flashStatus, flashFailAddr, 1'b0);
        else if (flashDone)
          d = reply(q, `KICH_STS_OK, `KICH_UNUSED_WORD, `KICH_UNUSED_WORD, 1'b0);
      end
      kich_pkg::ST_SEND: begin
        // walk the fifteen reply bytes
        if (q.txValid && txReady) begin
          if (q.txIdx == `KICH_TX_LAST) begin
            d.txValid = 1'b0;
            d.st = kich_pkg::ST_HUNT; // back to waiting
            d.isData = q.afterOk;
          end else begin
            d.txIdx = q.txIdx + 4'h1;
            d.txByte = replyByte(q, d.txIdx);
          end
        end
      end
    endcase
    // apb slave: one wait state, error on unmapped address
    d.pready = psel & penable & ~q.pready;
    d.pslverr = 1'b0;
    if (psel && penable && !q.pready) begin
      d.prdata = `KICH_RST_WORD;
      unique case (paddr)
        `KICH_REG_CTRL: d.prdata = {30'h0, q.ctrl};
        `KICH_REG_AREA_START: d.prdata = q.areaStart;
        `KICH_REG_AREA_END: d.prdata = q.areaEnd;
        `KICH_REG_SPLIT: d.prdata = q.split;
        `KICH_REG_WAU: d.prdata = q.write_access_unit;
        `KICH_REG_SEC_END: d.prdata = q.secEnd;
        `KICH_REG_PROT_START: d.prdata = q.protStart;
        `KICH_REG_PROT_END: d.prdata = q.protEnd;
        `KICH_REG_STATUS: d.prdata = {20'h0, q.st, q.sts};
        default: d.pslverr = 1'b1;
      endcase
    end
    if (apbAcc && pwrite) begin
      unique case (paddr)
        `KICH_REG_CTRL: d.ctrl = pwdata[1:0];
        `KICH_REG_AREA_START: d.areaStart = pwdata;
        `KICH_REG_AREA_END: d.areaEnd = pwdata;
        `KICH_REG_SPLIT: d.split = pwdata;
        `KICH_REG_WAU: d.write_access_unit = pwdata;
        `KICH_REG_SEC_END: d.secEnd = pwdata;
        `KICH_REG_PROT_START: d.protStart = pwdata;
        `KICH_REG_PROT_END: d.protEnd = pwdata;
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= kich_pkg::ST_HUNT;
    end else begin
      q <= d;
    end
  end
  // outputs straight from the state register
  assign txValid = q.txValid;
  assign txByte = q.txByte;
  assign keyValid = q.keyValid;
  assign keyByte = q.keyByte;
  assign genReq = q.genReq;
  assign genType = q.ktype;
  assign flashReq = q.flashReq;
  assign flashAddr = q.addr;
  assign flashLen = q.idxSize;
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_errCode;
    q.st == kich_pkg::ST_SEND && q.txIdx == 4'h3 && q.sts != `KICH_STS_OK;
  endsequence
  property p_errReply;
    s_errCode |-> q.txByte == `KICH_ERR_REPLY && q.txValid;
  endproperty
  a_errReply: assert property (p_errReply) else $error("error reply code wrong");
  property p_flashErr;
    q.st == kich_pkg::ST_FLASH && flashFail |=> q.sts == `KICH_STS_FLASH &&
      q.detail == $past(flashStatus) && q.failAddr == $past(flashFailAddr);
  endproperty
  a_flashErr: assert property (p_flashErr) else $error("flash error reply wrong");
  property p_hunt;
    q.st == kich_pkg::ST_HUNT && rxValid && rxByte != `KICH_CMD_START && !q.isData
      |=> q.st == kich_pkg::ST_HUNT;
  endproperty
  a_hunt: assert property (p_hunt) else $error("stray byte left hunt");
  property p_okSum;
    q.st == kich_pkg::ST_SEND && q.txIdx == 4'hd && q.sts == `KICH_STS_OK
      |-> q.txByte == 8'hd4;
  endproperty
  a_okSum: assert property (p_okSum) else $error("ok check byte wrong");
  property p_holdQuiet;
    $rose(q.st == kich_pkg::ST_HOLD) |-> q.delayCnt == 32'(ERR_DELAY_CYCLES - 1)
      ##1 (!q.txValid)[*3];
  endproperty
  a_holdQuiet: assert property (p_holdQuiet) else $error("delay not started");
  property p_abnormal;
    q.st == kich_pkg::ST_GEN && genAbnormal |=> q.st == kich_pkg::ST_HUNT && !q.txValid;
  endproperty
  a_abnormal: assert property (p_abnormal) else $error("reply after abnormal");
  property p_genFail;
    q.st == kich_pkg::ST_GEN && genFail && !genAbnormal |=>
      q.sts == `KICH_STS_TRUST && !q.flashReq ##1 !q.flashReq;
  endproperty
  a_genFail: assert property (p_genFail) else $error("trusted error wrong");
  sequence s_sendDone;
    q.st == kich_pkg::ST_SEND && q.txValid && txReady && q.txIdx == `KICH_TX_LAST;
  endsequence
  property p_rewait;
    s_sendDone |-> q.txByte == `KICH_END_MARK ##1 q.st == kich_pkg::ST_HUNT && !q.txValid;
  endproperty
  a_rewait: assert property (p_rewait) else $error("no return to wait");
  property p_accept;
    q.st == kich_pkg::ST_CHECK && !q.ctrl[0] |=> q.sts == `KICH_STS_ACC && !q.afterOk;
  endproperty
  a_accept: assert property (p_accept) else $error("acceptance not refused");
endmodule : kich_handler

/* core/kich_params.svh */
// constants of the key install command handler
`ifndef KICH_PARAMS_SVH
`define KICH_PARAMS_SVH
// framing bytes
`define KICH_CMD_START 8'h01
`define KICH_DATA_START 8'h81
`define KICH_END_MARK 8'h03
`define KICH_CMD_CODE 8'h2a
`define KICH_ERR_REPLY 8'haa
`define KICH_REPLY_LEN_HI 8'h00
`define KICH_REPLY_LEN_LO 8'h0a
`define KICH_UNUSED_WORD 32'hffffffff
// length figures of command and data packets
`define KICH_CMD_LEN 16'h0006
`define KICH_FIRST_HDR 16'h0031
`define KICH_FIRST_MIN 16'h0032
`define KICH_LATER_MIN 16'h0002
`define KICH_DATA_MAX 16'h0401
// status codes
`define KICH_STS_OK 8'h00
`define KICH_STS_FLASH 8'he5
`define KICH_STS_PKT 8'hc1
`define KICH_STS_SUM 8'hc2
`define KICH_STS_ACC 8'hc3
`define KICH_STS_PARAM 8'hc4
`define KICH_STS_SEC 8'hc5
`define KICH_STS_PROT 8'hc6
`define KICH_STS_TRUST 8'hc7
// reply layout: last byte index
`define KICH_TX_LAST 4'he
// timing
`define KICH_ERR_DELAY_S 5
`define KICH_CLK_HZ 100000000
// register offsets
`define KICH_REG_CTRL 8'h00
`define KICH_REG_AREA_START 8'h04
`define KICH_REG_AREA_END 8'h08
`define KICH_REG_SPLIT 8'h0c
`define KICH_REG_WAU 8'h10
`define KICH_REG_SEC_END 8'h14
`define KICH_REG_PROT_START 8'h18
`define KICH_REG_PROT_END 8'h1c
`define KICH_REG_STATUS 8'h20
// reset values
`define KICH_RST_WORD 32'h00000000
`endif

/* core/kich_pkg.sv */
// types of the key install command handler
package kich_pkg;
  typedef enum logic [3:0] {
    ST_HUNT, ST_LENH, ST_LENL, ST_BODY, ST_SUMB, ST_ENDB,
    ST_CHECK, ST_HOLD, ST_GEN, ST_FLASH, ST_SEND
  } kich_state_t;
  typedef struct packed {
    kich_state_t st;
    logic isData, firstPkt, resOk, overflow, afterOk;
    logic [15:0] len, idx;
    logic [7:0] sum, code, ktype, sts, pendSts, txByte, keyByte;
    logic [31:0] addr, detail, failAddr, delayCnt;
    logic [11:0] keyCnt, instSize, idxSize;
    logic [3:0] txIdx;
    logic txValid, keyValid, genReq, flashReq;
    logic [1:0] ctrl;
    logic [31:0] areaStart, areaEnd, split, write_access_unit, secEnd, protStart, protEnd, prdata;
    logic pready, pslverr;
  } kich_regs_t;
endpackage : kich_pkg

/* test/kich_handler_bench.sv */
// testbench of the key install command handler
module kich_handler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned DLY = 200; // shortened error delay
  localparam logic [7:0] RA[8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h00};
  localparam logic [31:0] RV[8] = '{0, 'h10000, 'h8000, 4, 'h2000, 'hf000, 'hf100, 0};
  localparam logic [31:0] PA[6] = '{'hf000, 'h3002, 'h20000, 'h7ff0, 'hf000, 'h1000};
  localparam logic [7:0] PT[6] = '{8'h04, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05};
  localparam logic [7:0] PS[6] = '{8'hc4, 8'hc4, 8'hc4, 8'hc4, 8'hc6, 8'hc5};
  logic clk, rst, rxValid, txValid, txReady, keyValid, genReq, genDone, flashReq, flashDone;
  logic flashFail, psel, penable, pwrite, pready, pslverr, e, genFail, genAbnormal;
  logic [7:0] rxByte, txByte, keyByte, genType, paddr;
  logic [31:0] flashAddr, flashStatus, flashFailAddr, pwdata, prdata, rd;
  logic [11:0] flashLen;
  logic [7:0] body[$];
  logic [7:0] keyLog[$]; // key bytes seen on the key output
  int errors = 0, n_tests = 0, nFlash = 0, w;
  kich_handler #(.ERR_DELAY_CYCLES(DLY)) i_dut (.clk(clk), .rst(rst), .rxValid(rxValid),
    .rxByte(rxByte), .txValid(txValid), .txByte(txByte), .txReady(txReady),
    .keyValid(keyValid), .keyByte(keyByte), .genReq(genReq), .genType(genType),
    .genDone(genDone), .genFail(genFail), .genAbnormal(genAbnormal), .flashReq(flashReq),
    .flashAddr(flashAddr), .flashLen(flashLen), .flashDone(flashDone), .flashFail(flashFail),
    .flashStatus(flashStatus), .flashFailAddr(flashFailAddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  kich_host_model i_host (.clk(clk), .rxValid(rxValid), .rxByte(rxByte), .txValid(txValid),
    .txByte(txByte), .txReady(txReady));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // log key bytes and count write requests
  always @(posedge clk) begin
    if (keyValid === 1'b1) keyLog.push_back(keyByte);
    nFlash += (flashReq === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("%0d checks, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // bounded wait for a strobe of the design
  task automatic waitSig(input bit onFlash);
    int n;
    n = 0;
    while ((onFlash ? flashReq : genReq) !== 1'b1) begin
      @(posedge clk);
      if (++n > 3000) begin
        errors++;
        report_and_stop();
      end
    end
  endtask : waitSig
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (++n > 50) begin
        errors++;
        report_and_stop();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [31:0] a, input logic [7:0] t, sumAdj, endMark);
    body = {8'h00, 8'h06, 8'h2a, a[31:24], a[23:16], a[15:8], a[7:0], t};
    i_host.sendPkt(8'h01, body, sumAdj, endMark);
  endtask : cmd
  // collect fifteen reply bytes and compare with the worked-out packet
  task automatic reply(input logic [7:0] res, sts, input logic [31:0] det = '1, adr = '1);
    logic [7:0] x[$];
    logic [7:0] s;
    x = {8'h81, 8'h00, 8'h0a, res, sts, det[31:24], det[23:16], det[15:8], det[7:0],
         adr[31:24], adr[23:16], adr[15:8], adr[7:0]};
    s = 8'h00;
    for (int i = 1; i < 13; i++) s -= x[i];
    x.push_back(s);
    x.push_back(8'h03);
    w = 0;
    while (i_host.reply.size() < 15) begin
      @(posedge clk);
      if (++w > 3000) begin
        errors++;
        report_and_stop();
      end
    end
    foreach (x[i]) check(i_host.reply[i], x[i]);
    i_host.reply.delete();
  endtask : reply
  ////////////////////////////////////////////////////////////////////////////////
  task automatic testRegs;
    apb(1'b0, 8'h00, 0);
    check(rd, 0);
    apb(1'b0, 8'h40, 0);
    check({rd[30:0], e}, 1);
    apb(1'b1, 8'h00, '1);
    apb(1'b0, 8'h00, 0);
    check(rd, 3);
    foreach (RA[i]) apb(1'b1, RA[i], RV[i]);
    i_host.sendByte(8'h55); // stray byte before the start byte
    cmd('h3000, 5, 0, 3);
    reply(8'haa, 8'hc3);
    apb(1'b1, 8'h00, 1);
    cmd('h3000, 5, 1, 3);
    reply(8'haa, 8'hc2);
    cmd('h3000, 5, 1, 4);
    reply(8'haa, 8'hc1);
    body = {8'h00, 8'h05, 8'h2a, 8'h00, 8'h00, 8'h30, 8'h00}; // length one short
    i_host.sendPkt(8'h01, body, 8'h00, 8'h03);
    reply(8'haa, 8'hc1);
    $display("registers and framing done");
  endtask : testRegs
  task automatic testParams;
    foreach (PA[i]) begin
      apb(1'b1, 8'h00, i == 5 ? 3 : 1);
      cmd(PA[i], PT[i], 0, 3);
      reply(8'haa, PS[i]);
    end
    apb(1'b1, 8'h00, 1);
    // k=0 bad check byte, k=1 too many install bytes, k=2 wrong reply code
    for (int k = 0; k < 3; k++) begin
      cmd('h3000, 5, 0, 3);
      reply(8'h2a, 8'h00);
      body = {8'h00, k == 1 ? 8'h52 : 8'h32, k == 2 ? 8'h2b : 8'h2a};
      for (int i = 0; i < (k == 1 ? 81 : 49); i++) body.push_back(i[7:0]);
      i_host.sendPkt(8'h81, body, k == 0 ? 8'h01 : 8'h00, 8'h03);
      reply(8'haa, k == 0 ? 8'hc2 : k == 1 ? 8'hc4 : 8'hc1);
      check(w >= DLY, k != 1);
    end
    check(nFlash, 0);
    $display("parameter and data errors done");
  endtask : testParams
  // mode 0 clean install, 1 write fails, 2 generation fails, 3 trusted system abnormal
  task automatic testFlow(input int mode);
    i_host.slow = (mode == 1);
    cmd('h3000, 5, 0, 3);
    reply(8'h2a, 8'h00);
    body = {8'h00, 8'h51, 8'h2a}; // key and vector, then install data
    for (int i = 0; i < 80; i++) body.push_back(i[7:0]);
    keyLog.delete();
    i_host.sendPkt(8'h81, body, 8'h00, 8'h03);
    waitSig(1'b0);
    check(keyLog.size(), 80);
    foreach (keyLog[i]) check(keyLog[i], i);
    check(genType, 5);
    genDone <= (mode < 2);
    genFail <= (mode == 2);
    genAbnormal <= (mode == 3);
    @(posedge clk);
    {genDone, genFail, genAbnormal} <= 3'h0;
    if (mode == 2) begin
      reply(8'haa, 8'hc7);
      check(nFlash, 0);
    end else if (mode == 3) begin
      repeat (40) @(posedge clk);
      check(i_host.reply.size(), 0);
      check(nFlash, 0);
    end else begin
      waitSig(1'b1);
      check(flashAddr, 'h3000);
      check(flashLen, 36);
      flashFail <= (mode == 1);
      flashDone <= (mode == 0);
      @(posedge clk);
      flashFail <= 1'b0;
      flashDone <= 1'b0;
      if (mode == 1) begin
        reply(8'haa, 8'he5, 'h12345678, 'h3004);
        apb(1'b0, 8'h20, 0);
        check(rd, {20'h0, kich_pkg::ST_HUNT, 8'he5});
      end else reply(8'h2a, 8'h00);
    end
    $display("key install flow done");
  endtask : testFlow
  initial begin
    {rst, psel, penable, pwrite, genDone, genFail, genAbnormal, flashDone, flashFail} = 9'h100;
    {paddr, pwdata, flashStatus, flashFailAddr} = {8'h00, 32'h0, 32'h12345678, 32'h3004};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    testRegs();
    testParams();
    testFlow(2);
    testFlow(3);
    testFlow(1);
    testFlow(0);
    report_and_stop();
  end
endmodule : kich_handler_bench

/* test/kich_host_model.sv */
// host side model: sends link bytes and collects reply bytes
module kich_host_model (
  input wire logic clk, // system clock
  output logic rxValid, // byte strobe to device
  output logic [7:0] rxByte, // byte to device
  input wire logic txValid, // reply byte offered
  input wire logic [7:0] txByte, // reply byte
  output logic txReady // reply byte taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0; // ready only on every other cycle
  logic [7:0] reply[$]; // collected reply bytes
  initial begin
    rxValid = 1'b0;
    rxByte = 8'h00;
    txReady = 1'b0;
  end
  // take reply bytes, slowly on request
  always @(posedge clk) begin
    if (txValid === 1'b1 && txReady) reply.push_back(txByte);
    txReady <= slow ? ~txReady : 1'b1;
  end
  // one byte, strobe held for one edge
  task automatic sendByte(input logic [7:0] b);
    @(posedge clk);
    rxValid <= 1'b1;
    rxByte <= b;
    @(posedge clk);
    rxValid <= 1'b0;
    rxByte <= ~b; // idle line shows no stale byte
  endtask : sendByte
  // start byte, body, check byte, end mark
  task automatic sendPkt(input logic [7:0] st, input logic [7:0] body[$],
                         input logic [7:0] sumAdj, input logic [7:0] endMark);
    logic [7:0] s;
    s = 8'h00;
    sendByte(st);
    foreach (body[i]) begin
      s -= body[i];
      sendByte(body[i]);
    end
    sendByte(s + sumAdj);
    sendByte(endMark);
  endtask : sendPkt
endmodule : kich_host_model
